// ### hdl/ddr_sram_pkg.sv
// Constants and types shared by the double-data-rate burst SRAM port.
package ddr_sram_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W    = 20;   // Burst address, one per 36-bit entry.
  localparam int DATA_W    = 18;   // One word on the data pins.
  localparam int BYTE_W    = 9;    // One byte lane, parity included.
  localparam int BWS_W     = 2;    // Byte selects per word.
  localparam int ENTRY_W   = 36;   // Two words of one burst.
  localparam int LANES     = 4;    // Byte lanes in one entry.
  localparam int MEM_AW    = 4;    // Address bits that index the model store.
  localparam int MEM_DEPTH = 16;   // Entries held in flip-flops.

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int PLL_LOCK_US       = 20;
  localparam int PLL_LOCK_CYC      =
    (PLL_LOCK_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int PLL_STOP_NS       = 30;
  localparam int PLL_STOP_CYC      =
    (PLL_STOP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int PLL_CNT_W         = 11;
  localparam int STOP_CNT_W        = 2;
  localparam int IMP_CAL_PERIOD    = 1024; // Counted in input clock cycles.
  localparam int IMP_CNT_W         = 10;
  localparam int IMP_CODE_W        = 4;

  // ---------------------------------------------------------------------
  // Reset value and limits of the impedance code
  // ---------------------------------------------------------------------
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_RST = 4'h8;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX = 4'hF;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN = 4'h0;

  // ---------------------------------------------------------------------
  // Commands decoded at a positive input clock rise
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP   = 2'b00,
    CMD_READ  = 2'b01,
    CMD_WRITE = 2'b10
  } cmd_t;

endpackage

// ### hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync_out
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg     <= '0;
      pin_sync_out <= '0;
    end else begin
      meta_reg     <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

endmodule

// ### hdl/ddr_burst_sram_port.sv
// Device-side logic of a double-data-rate burst SRAM port.
`timescale 1ns/1ns

// Notes on behaviour
// - Read latency two input cycles with PLL enabled, one with it off.
// - Accesses start only at a positive input clock rise.
// - Write and read data register on both input clock rises.
// - Control inputs register only on the positive input clock rise.
// - Every access is a burst of two words from sequential locations.
// - Read starts on read high, strobe low; address goes to read register.
// - First read word after two positive rises with PLL on, one with it off; second on next negative.
// - Reads always complete; a new read may start every positive rise.
// - Deselected reads finish, then output floats after next positive rise.
// - Write starts on read low, strobe low; address goes to write register.
// - Write words latched next positive rise then negative rise, per byte.
// - Both words commit as one 36-bit entry; back-to-back writes stream.
// - Deselected writes finish pending work and then ignore inputs.
// - Byte selects sampled with each word; deasserted leaves byte unchanged.
// - Write held in registers across reads, committed on next write.
// - Read of just-written address returns data from pending registers.
// - Output impedance recalibrates against reference every 1024 cycles.
// - Two free-running echo clocks follow the positive and negative clock.
// - Valid flag is aligned with echo clocks, half cycle before data.
// - PLL locks 20 us after stable clock; 30 ns stop resets it.
// - Strobe high is no-operation; outputs float, power-up is deselected.
// - Second burst word is the upper half of the entry at the latched address.
module ddr_burst_sram_port
  import ddr_sram_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  positive_input_timing,
  input  wire logic                  negative_input_timing,
  input  wire logic                  load_strobe_n,
  input  wire logic                  read_not_write,
  input  wire logic [BWS_W-1:0]      byte_write_sel_n,
  input  wire logic [ADDR_W-1:0]     burst_addr,
  input  wire logic [DATA_W-1:0]     write_bus,
  input  wire logic                  pll_off_n,
  input  wire logic                  impedance_ref_pin,
  output logic      [DATA_W-1:0]     read_out,
  output logic                       read_out_oe,
  output logic                       echo_strobe_true,
  output logic                       echo_strobe_comp,
  output logic                       read_valid_flag,
  output logic                       pll_locked,
  output logic      [IMP_CODE_W-1:0] drive_imp_code
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                                k_prev;
    logic                                kn_prev;
    logic                                echo_t;
    logic                                echo_c;
    logic [PLL_CNT_W-1:0]                pll_cnt;
    logic                                locked;
    logic [STOP_CNT_W-1:0]               stop_cnt;
    logic [1:0]                          rd_v;
    logic [ADDR_W-1:0]                   rd_a0;
    logic [ADDR_W-1:0]                   rd_a1;
    logic                                cap_arm;
    logic [ADDR_W-1:0]                   cap_addr;
    logic                                fill_hi;
    logic                                pend_v;
    logic [ADDR_W-1:0]                   pend_addr;
    logic [ENTRY_W-1:0]                  pend_data;
    logic [LANES-1:0]                    pend_mask;
    logic [MEM_DEPTH-1:0][ENTRY_W-1:0]   mem;
    logic [DATA_W-1:0]                   out_data;
    logic                                out_oe;
    logic [ADDR_W-1:0]                   out_addr;
    logic                                vld;
    logic [IMP_CNT_W-1:0]                imp_cnt;
    logic [IMP_CODE_W-1:0]               imp_code;
  } st_t;

  st_t                 st_reg;
  st_t                 st_next;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  localparam int SYNC_W = 6 + BWS_W + ADDR_W + DATA_W;

  logic [SYNC_W-1:0]   sync_q;
  logic                k_s;
  logic                kn_s;
  logic                load_n_s;
  logic                rnw_s;
  logic [BWS_W-1:0]    bws_n_s;
  logic [ADDR_W-1:0]   addr_s;
  logic [DATA_W-1:0]   wdata_s;
  logic                pll_on_s;
  logic                zq_s;

  // Every pin crosses two flops, so data and clocks stay aligned.
  pin_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .pin_in       ({positive_input_timing, negative_input_timing,
                    load_strobe_n, read_not_write, byte_write_sel_n,
                    burst_addr, write_bus, pll_off_n, impedance_ref_pin}),
    .pin_sync_out (sync_q)
  );

  // Unpack the synchronised pins.
  assign {k_s, kn_s, load_n_s, rnw_s, bws_n_s, addr_s, wdata_s, pll_on_s,
          zq_s} = sync_q;

  // ---------------------------------------------------------------------
  // Read fetch with pending-write bypass
  // ---------------------------------------------------------------------
  // Returns one half of the entry at a, newest bytes from pending registers.
  function automatic logic [DATA_W-1:0] fetch_word(
    input st_t               s,
    input logic [ADDR_W-1:0] a,
    input logic              hi
  );
    logic [ENTRY_W-1:0] e;
    e = s.mem[a[MEM_AW-1:0]];
    if (s.pend_v && (s.pend_addr == a)) begin
      for (int b = 0; b < LANES; b++) begin
        if (s.pend_mask[b]) begin
          e[b*BYTE_W +: BYTE_W] = s.pend_data[b*BYTE_W +: BYTE_W];
        end
      end
    end
    fetch_word = hi ? e[ENTRY_W-1:DATA_W] : e[DATA_W-1:0];
  endfunction

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic                k_rise;
  logic                kn_rise;
  logic                lat2;
  logic                src_v;
  logic [ADDR_W-1:0]   src_a;
  logic [ADDR_W-1:0]   cidx;
  cmd_t                cmd;

  // Edge finding, command decode and all pipeline updates.
  always_comb begin
    st_next = st_reg;
    k_rise  = k_s & ~st_reg.k_prev;
    kn_rise = kn_s & ~st_reg.kn_prev;
    lat2    = pll_on_s;
    src_v   = lat2 ? st_reg.rd_v[1] : st_reg.rd_v[0];
    src_a   = lat2 ? st_reg.rd_a1 : st_reg.rd_a0;
    cidx    = st_reg.pend_addr;
    st_next.k_prev  = k_s;
    st_next.kn_prev = kn_s;

    // Echo clocks run free, one flop behind the sampled input clocks.
    st_next.echo_t = k_s;
    st_next.echo_c = kn_s;

    // Equal levels on both input clocks mean the clock is stopped.
    if (k_s == kn_s) begin
      if (st_reg.stop_cnt != STOP_CNT_W'(PLL_STOP_CYC)) begin
        st_next.stop_cnt = st_reg.stop_cnt + 1'b1;
      end
    end else begin
      st_next.stop_cnt = '0;
    end

    // Lock counts stable clock time; a stop or PLL off restarts it.
    if (!pll_on_s || (st_reg.stop_cnt == STOP_CNT_W'(PLL_STOP_CYC))) begin
      st_next.pll_cnt = '0;
      st_next.locked  = 1'b0;
    end else if (st_reg.pll_cnt == PLL_CNT_W'(PLL_LOCK_CYC)) begin
      st_next.locked = 1'b1;
    end else begin
      st_next.pll_cnt = st_reg.pll_cnt + 1'b1;
    end

    // Controls are only looked at on a positive clock rise.
    if (load_n_s) begin
      cmd = CMD_NOP;
    end else if (rnw_s) begin
      cmd = CMD_READ;
    end else begin
      cmd = CMD_WRITE;
    end

    if (k_rise) begin
      // First word of a due burst, otherwise let the output float.
      st_next.out_oe = src_v;
      if (src_v) begin
        st_next.out_data = fetch_word(st_reg, src_a, 1'b0);
        st_next.out_addr = src_a;
      end

      // Read pipeline: one entry per positive rise, never cancelled.
      st_next.rd_v  = {st_reg.rd_v[0], 1'b0};
      st_next.rd_a1 = st_reg.rd_a0;
      unique case (cmd)
        CMD_READ: begin
          st_next.rd_v[0] = 1'b1;
          st_next.rd_a0   = addr_s;
        end
        CMD_WRITE: begin
          st_next.cap_addr = addr_s;
        end
        CMD_NOP: begin
        end
      endcase
      st_next.cap_arm = (cmd == CMD_WRITE);

      // Data phase of an armed write: retire the posted entry first.
      if (st_reg.cap_arm) begin
        if (st_reg.pend_v) begin
          for (int b = 0; b < LANES; b++) begin
            if (st_reg.pend_mask[b]) begin
              st_next.mem[cidx[MEM_AW-1:0]][b*BYTE_W +: BYTE_W] =
                st_reg.pend_data[b*BYTE_W +: BYTE_W];
            end
          end
        end
        st_next.pend_v    = 1'b1;
        st_next.pend_addr = st_reg.cap_addr;
        st_next.pend_data = {{DATA_W{1'b0}}, wdata_s};
        st_next.pend_mask = {2'b00, ~bws_n_s};
        st_next.fill_hi   = 1'b1;
      end

      // Impedance update once per calibration period of input cycles.
      if (st_reg.imp_cnt == IMP_CNT_W'(IMP_CAL_PERIOD - 1)) begin
        st_next.imp_cnt = '0;
        if (zq_s && (st_reg.imp_code != IMP_CODE_MAX)) begin
          st_next.imp_code = st_reg.imp_code + 1'b1;
        end else if (!zq_s && (st_reg.imp_code != IMP_CODE_MIN)) begin
          st_next.imp_code = st_reg.imp_code - 1'b1;
        end
      end else begin
        st_next.imp_cnt = st_reg.imp_cnt + 1'b1;
      end
    end

    if (kn_rise) begin
      // Second word of the burst being driven.
      if (st_reg.out_oe) begin
        st_next.out_data = fetch_word(st_reg, st_reg.out_addr, 1'b1);
      end
      // Flag leads the first word by half a cycle.
      st_next.vld = lat2 ? st_reg.rd_v[1] : st_reg.rd_v[0];
      // Second write word joins the same entry.
      if (st_reg.fill_hi) begin
        st_next.pend_data[ENTRY_W-1:DATA_W] = wdata_s;
        st_next.pend_mask[LANES-1:2]        = ~bws_n_s;
        st_next.fill_hi                     = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Power-up leaves the port deselected with its output floating.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg          <= '0;
      st_reg.imp_code <= IMP_CODE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Every output is a field of the state register.
  assign read_out         = st_reg.out_data;
  assign read_out_oe      = st_reg.out_oe;
  assign echo_strobe_true = st_reg.echo_t;
  assign echo_strobe_comp = st_reg.echo_c;
  assign read_valid_flag  = st_reg.vld;
  assign pll_locked       = st_reg.locked;
  assign drive_imp_code   = st_reg.imp_code;

endmodule

// ### testbench/sram_port_asserts.sv
// Concurrent checks on the pins of the double-data-rate SRAM port.
`timescale 1ns/1ns
module sram_port_asserts
  import ddr_sram_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire logic                  positive_input_timing,
  input wire logic                  negative_input_timing,
  input wire logic                  pll_off_n,
  input wire logic [DATA_W-1:0]     read_out,
  input wire logic                  read_out_oe,
  input wire logic                  echo_strobe_true,
  input wire logic                  echo_strobe_comp,
  input wire logic                  read_valid_flag,
  input wire logic                  pll_locked,
  input wire logic [IMP_CODE_W-1:0] drive_imp_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Counts cycles with the PLL enabled and the input clocks apart.
  int lock_cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      lock_cnt <= 0;
    else if (!pll_off_n || positive_input_timing == negative_input_timing)
      lock_cnt <= 0;
    else
      lock_cnt <= lock_cnt + 1;
  end

  echo_true_a: assert property (
    $rose(positive_input_timing) |-> ##3 $rose(echo_strobe_true))
    else $error("true echo clock does not follow its input clock");
  echo_comp_a: assert property (
    $rose(negative_input_timing) |-> ##3 $rose(echo_strobe_comp))
    else $error("complement echo clock does not follow its input clock");
  imp_step_a: assert property (
    $changed(drive_imp_code) |-> drive_imp_code == $past(drive_imp_code)
      + 4'h1 || drive_imp_code == $past(drive_imp_code) - 4'h1)
    else $error("impedance code moved by more than one step");
  flag_lead_a: assert property (
    $rose(read_out_oe) |-> $past(read_valid_flag, 8))
    else $error("valid flag did not lead the data by half a cycle");
  oe_fall_a: assert property (
    $fell(read_out_oe) |-> $past(positive_input_timing, 3)
      && !$past(positive_input_timing, 4))
    else $error("output released away from a positive clock rise");
  out_edge_a: assert property (
    $changed(read_out) |-> $past(positive_input_timing, 3)
      != $past(positive_input_timing, 4) || $past(negative_input_timing, 3)
      != $past(negative_input_timing, 4))
    else $error("read data changed away from an input clock edge");
  pll_stop_a: assert property (
    (positive_input_timing == negative_input_timing) [*3] |->
      ##[1:6] !pll_locked)
    else $error("stopped input clocks did not reset the PLL");
  pll_lock_a: assert property (
    $rose(pll_locked) |-> lock_cnt >= 1990 && lock_cnt <= 2010)
    else $error("PLL lock time is wrong");
endmodule

bind ddr_burst_sram_port sram_port_asserts chk_u (.sys_clk, .nrst,
  .positive_input_timing, .negative_input_timing, .pll_off_n, .read_out,
  .read_out_oe, .echo_strobe_true, .echo_strobe_comp, .read_valid_flag,
  .pll_locked, .drive_imp_code);

// ### testbench/sram_ctl_model.sv
// Memory controller model that drives the port's input pins.
`timescale 1ns/1ns
module sram_ctl_model
  import ddr_sram_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         run,
  output logic              positive_input_timing,
  output logic              negative_input_timing,
  output logic              load_strobe_n,
  output logic              read_not_write,
  output logic [BWS_W-1:0]  byte_write_sel_n,
  output logic [ADDR_W-1:0] burst_addr,
  output logic [DATA_W-1:0] write_bus
);
  // A slot is {valid, read, addr, d0, d1, b0, b1}.
  logic [61:0] nx_reg, cur_reg, prev_reg;
  logic        nx_full = 1'b0;
  logic [3:0]  cnt_reg = 4'h0;
  logic [3:0]  cnt_next;

  // Hands over one command and waits until it is on the pins.
  task automatic put(input logic [61:0] c);
    nx_reg = c;
    nx_full = 1'b1;
    wait (!nx_full);
  endtask

  // Drives one data phase; an idle bus toggles so stale data never passes.
  task automatic phase(input logic [17:0] d, input logic [1:0] b);
    if (prev_reg[61] && !prev_reg[60]) begin
      write_bus = d;
      byte_write_sel_n = b;
    end else begin
      write_bus = ~write_bus;
      byte_write_sel_n = 2'h3;
    end
  endtask

  // Sixteen sys_clk per clock cycle; pins change a quarter cycle early.
  initial begin
    {positive_input_timing, negative_input_timing} = 2'b01;
    {load_strobe_n, read_not_write, byte_write_sel_n} = 4'hF;
    {burst_addr, write_bus, cur_reg, prev_reg} = '0;
  end
  always @(negedge sys_clk) begin
    cnt_next = run ? cnt_reg + 4'h1 : 4'h0;
    positive_input_timing = ~cnt_next[3] | !run;
    negative_input_timing = cnt_next[3] | !run;
    if (cnt_next == 4'hC) begin
      prev_reg = cur_reg;
      cur_reg = nx_full ? nx_reg : '0;
      nx_full = 1'b0;
      load_strobe_n = !cur_reg[61];
      read_not_write = cur_reg[60];
      burst_addr = cur_reg[61] ? cur_reg[59:40] : ~burst_addr;
      phase(prev_reg[39:22], prev_reg[3:2]);
    end
    if (cnt_next == 4'h4)
      phase(prev_reg[21:4], prev_reg[1:0]);
    cnt_reg = cnt_next;
  end
endmodule

// ### testbench/ddr_burst_sram_port_bench.sv
// Self-checking bench for the double-data-rate SRAM port.
`timescale 1ns/1ns
module ddr_burst_sram_port_bench
  import ddr_sram_pkg::*;
;
  logic sys_clk = 1'b0, nrst = 1'b0, run = 1'b1;
  logic pll_off_n = 1'b1, impedance_ref_pin = 1'b0;
  logic positive_input_timing, negative_input_timing, load_strobe_n;
  logic read_not_write, read_out_oe, echo_strobe_true, echo_strobe_comp;
  logic read_valid_flag, pll_locked;
  logic [BWS_W-1:0]      byte_write_sel_n;
  logic [ADDR_W-1:0]     burst_addr;
  logic [DATA_W-1:0]     write_bus, read_out;
  logic [IMP_CODE_W-1:0] drive_imp_code;
  logic [35:0]           mem [16];
  logic [17:0]           lo_a [64], hi_a [64];
  logic                  oe_a [64], fl_a [64];
  int                    num_errors = 0, checks = 0, kidx = 0;

  ddr_burst_sram_port dut_u (.sys_clk, .nrst, .positive_input_timing,
    .negative_input_timing, .load_strobe_n, .read_not_write,
    .byte_write_sel_n, .burst_addr, .write_bus, .pll_off_n,
    .impedance_ref_pin, .read_out, .read_out_oe, .echo_strobe_true,
    .echo_strobe_comp, .read_valid_flag, .pll_locked, .drive_imp_code);
  sram_ctl_model ctl_u (.sys_clk, .run, .positive_input_timing,
    .negative_input_timing, .load_strobe_n, .read_not_write,
    .byte_write_sel_n, .burst_addr, .write_bus);

  always #5 sys_clk = ~sys_clk;

  // Samples the outputs settled after each input clock rise.
  always @(posedge positive_input_timing) begin : cap_k
    int i;
    kidx++;
    i = kidx % 64;
    repeat (6) @(posedge sys_clk);
    lo_a[i] = read_out;
    oe_a[i] = read_out_oe;
  end
  always @(posedge negative_input_timing) begin : cap_kn
    int i;
    i = kidx % 64;
    repeat (6) @(posedge sys_clk);
    hi_a[i] = read_out;
    fl_a[i] = read_valid_flag;
  end

  // Counts one comparison and reports a mismatch at once.
  task chk(input logic [35:0] got, input logic [35:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, s, got, exp);
    end
  endtask
  task stop_test;
    $display("Counts: %0d checks, %0d errors", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Issues a write and merges its selected bytes into the expected store.
  task wr(input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1,
          input logic [1:0] b0, input logic [1:0] b1);
    ctl_u.put({2'b10, a, d0, d1, b0, b1});
    if (!b0[0]) mem[a[3:0]][8:0] = d0[8:0];
    if (!b0[1]) mem[a[3:0]][17:9] = d0[17:9];
    if (!b1[0]) mem[a[3:0]][26:18] = d1[8:0];
    if (!b1[1]) mem[a[3:0]][35:27] = d1[17:9];
  endtask
  task rd(input logic [19:0] a, output int t);
    ctl_u.put({2'b11, a, 40'h0});
    t = kidx + 1;
  endtask
  task rchk(input logic [19:0] a, input int t, input int l);
    int j;
    j = (t + l) % 64;
    chk({hi_a[j], lo_a[j]}, mem[a[3:0]], "read burst");
    chk(36'(oe_a[j]), 36'h1, "output enable in burst");
    chk(36'(fl_a[(t + l - 1) % 64]), 36'h1, "valid flag ahead of data");
  endtask
  task wcode(input logic [3:0] old);
    for (int n = 0; n < 20000 && drive_imp_code === old; n++)
      @(negedge sys_clk);
  endtask

  // Streamed writes, masked rewrites, bypass read and streamed reads.
  task t_rw;
    int ts [4];
    for (int i = 0; i < 4; i++)
      wr(20'(i), 18'h2AAAA ^ 18'(i), 18'h15555 ^ 18'(i), 2'h0, 2'h0);
    for (int i = 0; i < 4; i++)
      wr(20'(i), 18'h3C0F0 + 18'(i), 18'h0F3C3 + 18'(i), 2'(i), 2'(i));
    for (int i = 3; i >= 0; i--)
      rd(20'(i), ts[i]);
    repeat (6) @(posedge positive_input_timing);
    for (int i = 0; i < 4; i++)
      rchk(20'(i), ts[i], 2);
    chk(36'(oe_a[(ts[0] + 3) % 64]), 36'h0, "output floats");
    chk(36'(fl_a[(ts[0] + 2) % 64]), 36'h0, "flag drops");
    $display("t_rw done");
  endtask
  task t_lat1;
    int t;
    pll_off_n = 1'b0;
    repeat (2) @(posedge positive_input_timing);
    rd(20'h2, t);
    repeat (4) @(posedge positive_input_timing);
    rchk(20'h2, t, 1);
    pll_off_n = 1'b1;
    $display("t_lat1 done");
  endtask
  task t_pll;
    repeat (2100) @(negedge sys_clk);
    chk(36'(pll_locked), 36'h1, "PLL locked");
    run = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(36'(pll_locked), 36'h0, "PLL reset by stop");
    run = 1'b1;
    $display("t_pll done");
  endtask
  task t_imp;
    int k0;
    impedance_ref_pin = 1'b1;
    wcode(4'h8);
    chk(36'(drive_imp_code), 36'h9, "code raised");
    k0 = kidx;
    impedance_ref_pin = 1'b0;
    wcode(4'h9);
    chk(36'(drive_imp_code), 36'h8, "code lowered");
    chk(36'(kidx - k0), 36'h400, "recalibration period");
    $display("t_imp done");
  endtask

  // Main sequence: reset values first, then the scenarios.
  initial begin
    repeat (16) @(negedge sys_clk);
    chk(36'(read_out_oe), 36'h0, "output floats in reset");
    chk(36'(drive_imp_code), 36'h8, "code in reset");
    nrst = 1'b1;
    repeat (4) @(posedge positive_input_timing);
    t_rw;
    t_lat1;
    t_pll;
    t_imp;
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
